// *** src/sector_protect_global_ctrl.sv ***
// Sector protection bits with global protect/unprotect, lock bit and protection read.
// Assumes status byte 1 writes arrive as a strobe from the command decoder.
// Function
// - Unlocked write with bits 5..2 all ones sets every protection bit.
// - Unlocked write with bits 5..2 all zeros clears every protection bit.
// - Mixed bits 5..2 leave protection unchanged; lock bit still updated.
// - Only bit 7 is stored as lock bit; bits 5..2 decoded only.
// - Pin low and lock set: write ignored entirely, lock stays one.
// - Pin high and lock set: no global operation, bit 7 may clear lock.
// - Writing 0Fh with pin deasserted clears lock without protection change.
// - Writing F0h while unlocked sets lock, protection untouched.
// - Writing FFh while unlocked protects globally and sets lock together.
// - Global protect during suspend aborts, no change, write enable latch cleared.
// - Status read bits 4..2 show pin state (bit 4) and protection summary (bits 3..2).
// - After address, output repeats FFh if protected, 00h if not.
// - Chip select high ends read and floats output, any bit.
// - Protection read reflects only stored bit, never the pin.
// - Summary bits tell whether all, some or no sectors are protected.
// - Every protection bit resets to one.
`timescale 1ns/1ns
`default_nettype none
module sector_protect_global_ctrl
   import spg_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                sys_rst_i,
   input  wire logic                spi_sck_i,
   input  wire logic                spi_cs_n_i,
   input  wire logic                spi_si_i,
   input  wire logic                wp_n_i,
   input  wire logic                sr1_wr_stb_i,
   input  wire logic [7:0]          sr1_wr_data_i,
   input  wire logic                write_enable_latch_i,
   input  wire logic                suspend_i,
   output logic                     spi_so_o,
   output logic                     spi_so_oe_o,
   output logic                     protection_lock_bit_o,
   output logic                     write_enable_latch_clr_o,
   output logic [1:0]               soft_protect_summary_o,
   output logic [7:0]               sr1_rd_o,
   output logic [NUM_SECT-1:0]      sect_prot_o
);
   spg_link_if lnk ();

   spg_pin_sync u_sync (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .spi_sck_i  (spi_sck_i),
      .spi_cs_n_i (spi_cs_n_i),
      .spi_si_i   (spi_si_i),
      .wp_n_i     (wp_n_i),
      .lnk        (lnk)
   );

   function automatic logic [1:0] sum_of(input logic [NUM_SECT-1:0] p);
      if (&p)
         return SUM_ALL;
      else if (|p)
         return SUM_SOME;
      else
         return SUM_NONE;
   endfunction

   // Protection and lock state
   logic [NUM_SECT-1:0] prot_r;
   logic [NUM_SECT-1:0] prot_nxt;
   logic                lock_r;
   logic                lock_nxt;
   logic                abort_r;
   logic                abort_nxt;
   logic [1:0]          sum_r;
   logic [1:0]          sum_nxt;
   logic [7:0]          sr_r;
   logic [7:0]          sr_nxt;
   logic                wr_ok;
   logic                hw_lock;
   logic [3:0]          glb;

   assign wr_ok   = sr1_wr_stb_i & write_enable_latch_i;
   assign hw_lock = lock_r & ~lnk.wp_n;
   assign glb     = sr1_wr_data_i[GLB_HI:GLB_LO];

   always_comb begin
      prot_nxt    = prot_r;
      lock_nxt    = lock_r;
      abort_nxt   = 1'b0;
      if (wr_ok && !hw_lock) begin
         if (lock_r) begin
            lock_nxt = sr1_wr_data_i[LOCK_POS];
         end else if (glb == GLB_PROT && suspend_i) begin
            abort_nxt = 1'b1;
         end else begin
            lock_nxt = sr1_wr_data_i[LOCK_POS];
            if (glb == GLB_PROT)
               prot_nxt = {NUM_SECT{1'b1}};
            else if (glb == GLB_UNPROT)
               prot_nxt = {NUM_SECT{1'b0}};
         end
      end
      sum_nxt = sum_of(prot_r);
      sr_nxt  = SR_RST;
      sr_nxt[LOCK_POS]            = lock_r;
      sr_nxt[SR_WP_POS]           = lnk.wp_n;
      sr_nxt[SR_SUM_HI:SR_SUM_LO] = sum_of(prot_r);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         prot_r    <= {NUM_SECT{PROT_RST}};
         lock_r    <= LOCK_RST;
         abort_r   <= 1'b0;
         sum_r     <= SUM_ALL;
         sr_r      <= SR_RST;
      end else begin
         prot_r    <= prot_nxt;
         lock_r    <= lock_nxt;
         abort_r   <= abort_nxt;
         sum_r     <= sum_nxt;
         sr_r      <= sr_nxt;
      end
   end

   // Protection read over the serial link
   spg_rd_state_e        st_r;
   spg_rd_state_e        st_nxt;
   logic [5:0]           cnt_r;
   logic [5:0]           cnt_nxt;
   logic [ADDR_BITS-1:0] sh_r;
   logic [ADDR_BITS-1:0] sh_nxt;
   logic                 sel_r;
   logic                 sel_nxt;
   logic                 so_r;
   logic                 so_nxt;
   logic                 oe_r;
   logic                 oe_nxt;
   logic [ADDR_BITS-1:0] sh_in;

   assign sh_in = {sh_r[ADDR_BITS-2:0], lnk.si_bit};

   always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      sh_nxt  = sh_r;
      sel_nxt = sel_r;
      so_nxt  = so_r;
      oe_nxt  = oe_r;
      if (!lnk.cs_act) begin
         st_nxt = ST_IDLE;
         oe_nxt = 1'b0;
         so_nxt = 1'b0;
      end else begin
         unique case (st_r)
            ST_IDLE: begin
               st_nxt  = ST_OPC;
               cnt_nxt = CNT_ZERO;
            end
            ST_OPC: if (lnk.sck_rise) begin
               sh_nxt  = sh_in;
               cnt_nxt = cnt_r + CNT_ONE;
               if (cnt_r == CNT_OPC_LAST) begin
                  cnt_nxt = CNT_ZERO;
                  st_nxt  = (sh_in[7:0] == OPC_RD_PROT) ? ST_ADDR : ST_SKIP;
               end
            end
            ST_ADDR: if (lnk.sck_rise) begin
               sh_nxt  = sh_in;
               cnt_nxt = cnt_r + CNT_ONE;
               if (cnt_r == CNT_ADDR_LAST) begin
                  // Captured once: later protection changes do not alter this read
                  sel_nxt = prot_r[sh_in[SECT_ADDR_HI:SECT_ADDR_LO]];
                  st_nxt  = ST_RESP;
               end
            end
            ST_RESP: if (lnk.sck_fall) begin
               oe_nxt = 1'b1;
               so_nxt = sel_r ? RESP_PROT[0] : RESP_UNPROT[0];
            end
            ST_SKIP: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_r  <= ST_IDLE;
         cnt_r <= CNT_ZERO;
         sh_r  <= {ADDR_BITS{1'b0}};
         sel_r <= PROT_RST;
         so_r  <= 1'b0;
         oe_r  <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r  <= sh_nxt;
         sel_r <= sel_nxt;
         so_r  <= so_nxt;
         oe_r  <= oe_nxt;
      end
   end

   assign spi_so_o                 = so_r;
   assign spi_so_oe_o              = oe_r;
   assign protection_lock_bit_o    = lock_r;
   assign write_enable_latch_clr_o = abort_r;
   assign soft_protect_summary_o   = sum_r;
   assign sr1_rd_o                 = sr_r;
   assign sect_prot_o              = prot_r;

   property p_glob_prot;
      @(posedge clk_i) disable iff (sys_rst_i)
      (wr_ok && !lock_r && glb == GLB_PROT && !suspend_i) |=> (&prot_r);
   endproperty
   a_glob_prot: assert property (p_glob_prot) else $error("global protect missed");

   property p_glob_unprot;
      @(posedge clk_i) disable iff (sys_rst_i)
      (wr_ok && !lock_r && glb == GLB_UNPROT) |=> (prot_r == '0) ##1 (sum_r == SUM_NONE);
   endproperty
   a_glob_unprot: assert property (p_glob_unprot) else $error("global unprotect missed");

   property p_mixed;
      @(posedge clk_i) disable iff (sys_rst_i)
      (wr_ok && glb != GLB_PROT && glb != GLB_UNPROT) |=> $stable(prot_r);
   endproperty
   a_mixed: assert property (p_mixed) else $error("mixed write changed protection");

   property p_lock_store;
      @(posedge clk_i) disable iff (sys_rst_i)
      (wr_ok && !hw_lock && !(glb == GLB_PROT && suspend_i && !lock_r))
         |=> (lock_r == $past(sr1_wr_data_i[LOCK_POS]));
   endproperty
   a_lock_store: assert property (p_lock_store) else $error("lock bit not stored");

   property p_hw_lock;
      @(posedge clk_i) disable iff (sys_rst_i)
      (wr_ok && hw_lock) |=> ($stable(prot_r) && lock_r);
   endproperty
   a_hw_lock: assert property (p_hw_lock) else $error("hardware lock breached");

   property p_soft_lock;
      @(posedge clk_i) disable iff (sys_rst_i)
      (wr_ok && lock_r && lnk.wp_n) |=> $stable(prot_r);
   endproperty
   a_soft_lock: assert property (p_soft_lock) else $error("global op while locked");

   property p_abort;
      @(posedge clk_i) disable iff (sys_rst_i)
      (wr_ok && !hw_lock && !lock_r && glb == GLB_PROT && suspend_i)
         |=> (write_enable_latch_clr_o && $stable(prot_r) && !lock_r);
   endproperty
   a_abort: assert property (p_abort) else $error("suspend abort failed");

   property p_resp;
      @(posedge clk_i) disable iff (sys_rst_i)
      (st_r == ST_RESP && lnk.cs_act && lnk.sck_fall) |=> (spi_so_oe_o && spi_so_o == sel_r);
   endproperty
   a_resp: assert property (p_resp) else $error("wrong protection read data");

   property p_cs_end;
      @(posedge clk_i) disable iff (sys_rst_i)
      !lnk.cs_act |=> (!spi_so_oe_o && st_r == ST_IDLE);
   endproperty
   a_cs_end: assert property (p_cs_end) else $error("output not floated");

   property p_summary;
      @(posedge clk_i) disable iff (sys_rst_i)
      // Skips the last reset edge, where the status view is still all zero
      !sys_rst_i |=> (soft_protect_summary_o == sum_of($past(prot_r))
                      && sr1_rd_o[SR_SUM_HI:SR_SUM_LO] == soft_protect_summary_o);
   endproperty
   a_summary: assert property (p_summary) else $error("summary mismatch");
endmodule
`default_nettype wire

// *** src/spg_pkg.sv ***
// Constants, field positions and state types of the sector protection block.
// Assumes one system clock; every other package user imports spg_pkg::*.
package spg_pkg;
   localparam int          NUM_SECT      = 64;
   localparam int          SECT_IDX_W    = 6;
   localparam int          ADDR_BITS     = 24;
   localparam int          SECT_ADDR_HI  = 21;
   localparam int          SECT_ADDR_LO  = 16;
   localparam logic [7:0]  OPC_RD_PROT   = 8'h3C;
   localparam logic [7:0]  RESP_PROT     = 8'hFF;
   localparam logic [7:0]  RESP_UNPROT   = 8'h00;
   localparam logic [5:0]  CNT_OPC_LAST  = 6'h07;
   localparam logic [5:0]  CNT_ADDR_LAST = 6'h17;
   localparam logic [5:0]  CNT_ONE       = 6'h01;
   localparam logic [5:0]  CNT_ZERO      = 6'h00;
   localparam int          LOCK_POS      = 7;
   localparam int          GLB_HI        = 5;
   localparam int          GLB_LO        = 2;
   localparam int          SR_WP_POS     = 4;
   localparam int          SR_SUM_HI     = 3;
   localparam int          SR_SUM_LO     = 2;
   localparam logic [3:0]  GLB_PROT      = 4'hF;
   localparam logic [3:0]  GLB_UNPROT    = 4'h0;
   localparam logic [1:0]  SUM_NONE      = 2'h0;
   localparam logic [1:0]  SUM_SOME      = 2'h1;
   localparam logic [1:0]  SUM_ALL       = 2'h3;
   localparam logic        PROT_RST      = 1'b1;
   localparam logic        LOCK_RST      = 1'b0;
   localparam logic [7:0]  SR_RST        = 8'h00;

   typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_RESP, ST_SKIP} spg_rd_state_e;
endpackage

// *** src/spg_link_if.sv ***
// Synchronised serial-link events passed from the pin front end to the core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
`default_nettype none
interface spg_link_if;
   logic sck_rise;
   logic sck_fall;
   logic cs_act;
   logic si_bit;
   logic wp_n;

   modport drv  (output sck_rise, output sck_fall, output cs_act, output si_bit, output wp_n);
   modport core (input sck_rise, input sck_fall, input cs_act, input si_bit, input wp_n);
endinterface
`default_nettype wire

// *** src/spg_pin_sync.sv ***
// Two-stage synchronisers for the serial pins and write-protect pin, plus clock edge finding.
// Assumes the serial clock is far slower than clk_i (at least four system cycles per half).
`timescale 1ns/1ns
`default_nettype none
module spg_pin_sync
   import spg_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic spi_sck_i,
   input  wire logic spi_cs_n_i,
   input  wire logic spi_si_i,
   input  wire logic wp_n_i,
   spg_link_if.drv   lnk
);
   logic [3:0] meta_r;
   logic [3:0] meta_nxt;
   logic [3:0] sync_r;
   logic [3:0] sync_nxt;
   logic       sck_d_r;
   logic       sck_d_nxt;

   always_comb begin
      meta_nxt  = {wp_n_i, spi_si_i, spi_cs_n_i, spi_sck_i};
      sync_nxt  = meta_r;
      sck_d_nxt = sync_r[0];
   end

   // Reset idles as CS high, write-protect deasserted
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_r  <= 4'hA;
         sync_r  <= 4'hA;
         sck_d_r <= 1'b0;
      end else begin
         meta_r  <= meta_nxt;
         sync_r  <= sync_nxt;
         sck_d_r <= sck_d_nxt;
      end
   end

   assign lnk.sck_rise = sync_r[0] & ~sck_d_r;
   assign lnk.sck_fall = ~sync_r[0] & sck_d_r;
   assign lnk.cs_act   = ~sync_r[1];
   assign lnk.si_bit   = sync_r[2];
   assign lnk.wp_n     = sync_r[3];
endmodule
`default_nettype wire

// *** testbench/spg_spi_host.sv ***
// Behavioural serial host that issues protection-read frames.
// Assumes a 20 MHz clk_i; serial clock period is eight clk_i cycles (400 ns).
`timescale 1ns/1ns
`default_nettype none
module spg_spi_host (
   input  wire logic clk_i,
   input  wire logic so_i,
   input  wire logic so_oe_i,
   output var  logic sck_o,
   output var  logic cs_n_o,
   output var  logic si_o
);
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end

   // Idle data line toggles so a stale bit never looks like a valid drive
   always @(posedge clk_i) begin
      if (cs_n_o) begin
         si_o <= ~si_o;
      end
   end

   // Serial clock only runs inside a frame; a released output reads inverted
   task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nb,
                     output logic [15:0] d);
      logic [31:0] f;
      f = {op, a};
      d = 16'h0000;
      @(posedge clk_i) cs_n_o <= 1'b0;
      for (int i = 31; i >= 0; i--) begin
         repeat (2) @(posedge clk_i);
         si_o <= f[i];
         repeat (2) @(posedge clk_i);
         sck_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         sck_o <= 1'b0;
      end
      for (int i = 0; i < nb; i++) begin
         repeat (4) @(posedge clk_i);
         sck_o <= 1'b1;
         repeat (3) @(posedge clk_i);
         d = {d[14:0], so_oe_i ? so_i : ~so_i};
         @(posedge clk_i) sck_o <= 1'b0;
      end
      repeat (2) @(posedge clk_i);
      cs_n_o <= 1'b1;
   endtask
endmodule
`default_nettype wire

// *** testbench/sector_protect_global_ctrl_bench.sv ***
// Self-checking bench: status writes and protection reads against a bench model.
// Assumes the design package and link interface are compiled first.
`timescale 1ns/1ns
`default_nettype none
module sector_protect_global_ctrl_bench
   import spg_pkg::*;
;
   logic                clk_i, sys_rst_i, wp_n_i, sr1_wr_stb_i, write_enable_latch_i, suspend_i;
   logic [7:0]          sr1_wr_data_i, sr1_rd_o;
   wire logic           sck, cs_n, si;
   logic                spi_so_o, spi_so_oe_o, protection_lock_bit_o, write_enable_latch_clr_o;
   logic [1:0]          soft_protect_summary_o;
   logic [NUM_SECT-1:0] sect_prot_o, m_prot;
   logic [31:0]         r;
   int                  n_fail = 0, total_checks = 0, seed = 68741, m_lock;
   logic [10:0]         seq [11] = '{11'h600, 11'h67F, 11'h600, 11'h604, 11'h6F0, 11'h20F,
                                     11'h67F, 11'h47F, 11'h37F, 11'h2FF, 11'h60F};

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   sector_protect_global_ctrl uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_sck_i(sck),
      .spi_cs_n_i(cs_n), .spi_si_i(si), .wp_n_i(wp_n_i), .sr1_wr_stb_i(sr1_wr_stb_i),
      .sr1_wr_data_i(sr1_wr_data_i), .write_enable_latch_i(write_enable_latch_i),
      .suspend_i(suspend_i), .spi_so_o(spi_so_o), .spi_so_oe_o(spi_so_oe_o),
      .protection_lock_bit_o(protection_lock_bit_o),
      .write_enable_latch_clr_o(write_enable_latch_clr_o),
      .soft_protect_summary_o(soft_protect_summary_o), .sr1_rd_o(sr1_rd_o),
      .sect_prot_o(sect_prot_o));

   spg_spi_host host (.clk_i(clk_i), .so_i(spi_so_o), .so_oe_i(spi_so_oe_o), .sck_o(sck),
      .cs_n_o(cs_n), .si_o(si));

   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   function automatic logic [1:0] sumx();
      return (&m_prot) ? SUM_ALL : ((|m_prot) ? SUM_SOME : SUM_NONE);
   endfunction

   task automatic chk_all();
      chk("sect_prot", sect_prot_o, m_prot);
      chk("lock", protection_lock_bit_o, m_lock[0]);
      chk("summary", soft_protect_summary_o, sumx());
      chk("sr1_rd", sr1_rd_o, {m_lock[0], 2'b00, wp_n_i, sumx(), 2'b00});
   endtask

   // Model decides the outcome before the strobe lands, from pre-write state
   task automatic wr(input logic wp, input logic we, input logic su, input logic [7:0] d);
      logic wc;
      wc = 1'b0;
      @(posedge clk_i);
      wp_n_i <= wp;
      write_enable_latch_i <= we;
      suspend_i <= su;
      repeat (4) @(posedge clk_i);
      sr1_wr_stb_i <= 1'b1;
      sr1_wr_data_i <= d;
      if (we && !(m_lock[0] && !wp)) begin
         if (m_lock[0]) m_lock = d[7];
         else if (d[5:2] == 4'hF && su) wc = 1'b1;
         else begin
            m_lock = d[7];
            if (d[5:2] == 4'hF) m_prot = '1;
            if (d[5:2] == 4'h0) m_prot = '0;
         end
      end
      @(posedge clk_i);
      sr1_wr_stb_i <= 1'b0;
      sr1_wr_data_i <= d ^ 8'hFF;
      #1 chk("latch_clr", write_enable_latch_clr_o, wc);
      repeat (3) @(posedge clk_i);
      #1 chk_all();
   endtask

   // Other opcodes leave the output released, which the host reads as ones
   task automatic rdchk(input logic [7:0] op, input logic [23:0] a, input int nb);
      logic [15:0] d;
      logic [15:0] e;
      e = (m_prot[a[21:16]] || op != 8'h3C) ? 16'((1 << nb) - 1) : 16'h0000;
      host.rd(op, a, nb, d);
      chk("so_data", d, e);
      repeat (8) @(posedge clk_i);
      #1 chk("so_oe", spi_so_oe_o, 1'b0);
   endtask

   initial begin
      repeat (100000) @(posedge clk_i);
      n_fail++;
      conclude();
   end

   initial begin
      sys_rst_i = 1'b1;
      wp_n_i = 1'b1;
      sr1_wr_stb_i = 1'b0;
      sr1_wr_data_i = 8'h00;
      write_enable_latch_i = 1'b0;
      suspend_i = 1'b0;
      m_lock = 0;
      m_prot = '1;
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1 chk_all();
      rdchk(8'h3C, 24'h12_3456, 16);
      foreach (seq[i]) wr(seq[i][10], seq[i][9], seq[i][8], seq[i][7:0]);
      wr(1'b0, 1'b1, 1'b0, 8'h00);
      rdchk(8'h3C, 24'h3A_0000, 11);
      wr(1'b0, 1'b1, 1'b0, 8'h7F);
      wr(1'b0, 1'b1, 1'b0, 8'h80);
      rdchk(8'h3C, 24'h05_FFFF, 16);
      rdchk(8'hC3, 24'h05_0000, 8);
      for (int k = 0; k < 40; k++) begin
         r = $random(seed);
         wr(r[8], r[9] | r[10], r[11] & r[12], r[7:0]);
         if (k % 8 == 0) rdchk(8'h3C, r[31:8], 16);
      end
      conclude();
   end
endmodule
`default_nettype wire
